// ==== tb/ecs_pipe_model.sv ====
// pipeline and interrupt controller model facing the cause block
`timescale 1ns/100ps
module ecs_pipe_model
	import ecs_pkg::*;
(
	input wire logic i_clk,
	output ecs_exc_t o_exc,
	output ecs_irq_return_instr_t o_irq_return_instr,
	output ecs_status_t o_status,
	output logic o_timer_irq,
	output logic o_perf_irq,
	output logic [2:0] o_req_level,
	output logic [4:0] o_spacing,
	output logic [3:0] o_mapped_set,
	output logic [3:0] o_exc_set
);
	initial begin
		o_exc = '0;
		o_irq_return_instr = '0;
		o_status = '0;
		o_timer_irq = 1'b0;
		o_perf_irq = 1'b0;
		o_req_level = 3'h0;
		o_spacing = 5'h00;
		o_mapped_set = 4'h0;
		o_exc_set = 4'h0;
	end

	// one-cycle exception pulse; qualifiers are garbage once it drops
	task automatic take_exc(input logic [4:0] c, input logic d,
		input logic [1:0] u, input logic a);
		@(posedge i_clk);
		o_exc <= '{1'b1, c, d, u, a};
		@(posedge i_clk);
		o_exc <= '{1'b0, ~c, ~d, ~u, ~a};
	endtask : take_exc

	task automatic do_irq_return_instr(input logic ch);
		@(posedge i_clk);
		o_irq_return_instr <= '{1'b1, ch};
		@(posedge i_clk);
		o_irq_return_instr <= '{1'b0, ~ch};
	endtask : do_irq_return_instr

	task automatic set_status(input logic x, input logic b, input logic e);
		@(posedge i_clk);
		o_status <= '{x, b, e};
	endtask : set_status

	task automatic set_lines(input logic t, input logic p,
		input logic [2:0] l);
		@(posedge i_clk);
		o_timer_irq <= t;
		o_perf_irq <= p;
		o_req_level <= l;
	endtask : set_lines

	task automatic set_ctl(input logic [4:0] s, input logic [3:0] m,
		input logic [3:0] e);
		@(posedge i_clk);
		o_spacing <= s;
		o_mapped_set <= m;
		o_exc_set <= e;
	endtask : set_ctl
endmodule : ecs_pipe_model

// ==== tb/testbench.sv ====
// self-checking bench of the exception cause block
`timescale 1ns/100ps
module testbench
	import ecs_pkg::*;
;
	logic clk;
	logic srst;
	logic we;
	logic [31:0] wdata;
	ecs_exc_t exc;
	ecs_irq_return_instr_t irq_return_instr;
	ecs_status_t st;
	logic tmr;
	logic prf;
	logic [2:0] lvl;
	logic [4:0] spc;
	logic [3:0] mset;
	logic [3:0] eset;
	logic [31:0] cause;
	logic [1:0] sexp;
	logic [1:0] sloc;
	logic halt;
	logic [31:0] cnt;
	logic [11:0] voff;
	logic vtab;
	logic [3:0] sset;
	int errors;
	int check_count;
	logic [31:0] c0;

	// ***********************************************************
	// instances
	// ***********************************************************
	ecs_pipe_model p (.i_clk(clk), .o_exc(exc), .o_irq_return_instr(irq_return_instr),
		.o_status(st), .o_timer_irq(tmr), .o_perf_irq(prf),
		.o_req_level(lvl), .o_spacing(spc), .o_mapped_set(mset),
		.o_exc_set(eset));

	ecs_cause DUT (.I_CLK(clk), .I_SRST(srst), .I_EXC(exc),
		.I_IRQ_RETURN_INSTR(irq_return_instr), .I_STATUS(st), .I_TIMER_IRQ(tmr),
		.I_PERF_IRQ(prf), .I_REQ_LEVEL(lvl), .I_VECTOR_SPACING(spc),
		.I_MAPPED_SET(mset), .I_EXC_SHADOW_SET(eset),
		.I_CAUSE_WE(we), .I_CAUSE_WDATA(wdata), .O_CAUSE(cause),
		.O_SOFT_IRQ_EXPORT(sexp), .O_SOFT_IRQ_LOCAL(sloc),
		.O_COUNT_HALT(halt), .O_CYCLE_COUNT(cnt),
		.O_VECTOR_OFFSET(voff), .O_VECTOR_TABLE(vtab),
		.O_SHADOW_SET(sset));

	// ***********************************************************
	// helpers
	// ***********************************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got,
				exp);
		end
	endtask : chk

	task automatic wr(input logic [31:0] d);
		@(posedge clk);
		we <= 1'b1;
		wdata <= d;
		@(posedge clk);
		we <= 1'b0;
		wdata <= ~d;
		#1;
	endtask : wr

	task automatic print_verdict();
		if (errors == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : print_verdict

	// ***********************************************************
	// scenarios
	// ***********************************************************
	task automatic t_reset();
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		#1;
		chk(cause, 32'h0000_0000);
		chk(voff, 12'h180);
		repeat (3) @(posedge clk);
		#1;
		chk(cnt, 32'h0000_0003);
	endtask : t_reset

	task automatic t_write();
		wr(32'hFFFF_FFFF);
		chk(cause, 32'h0880_0300);
		chk(halt, 1'b1);
		c0 = cnt;
		@(posedge clk);
		#1;
		chk(sloc, 2'h3);
		chk(sexp, 2'h0);
		repeat (2) @(posedge clk);
		#1;
		chk(cnt, c0);
		p.set_status(1'b0, 1'b0, 1'b1);
		repeat (2) @(posedge clk);
		#1;
		chk(sexp, 2'h3);
		chk(sloc, 2'h0);
		wr(32'h0000_0000);
		chk(cause, 32'h0000_0000);
		c0 = cnt;
		repeat (3) @(posedge clk);
		#1;
		chk(cnt, c0 + 32'h0000_0003);
	endtask : t_write

	task automatic t_codes();
		logic [4:0] codes [11];
		codes = '{5'h00, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09,
			5'h0A, 5'h0B, 5'h0C, 5'h0D};
		foreach (codes[i]) begin
			p.take_exc(codes[i], 1'b0, 2'h0, 1'b0);
			#1;
			chk(cause[6:2], codes[i]);
		end
		p.take_exc(5'h0E, 1'b0, 2'h0, 1'b0);
		#1;
		chk(cause[6:2], 5'h0A);
	endtask : t_codes

	task automatic t_delay();
		p.set_status(1'b0, 1'b0, 1'b0);
		p.take_exc(5'h0B, 1'b1, 2'h2, 1'b1);
		#1;
		chk(cause[31:28], 4'hA);
		chk(cause[24], 1'b1);
		p.set_status(1'b1, 1'b0, 1'b0);
		p.take_exc(5'h08, 1'b0, 2'h1, 1'b0);
		#1;
		chk(cause[31:28], 4'h9);
		chk(cause[24], 1'b0);
		p.set_status(1'b0, 1'b0, 1'b0);
		p.take_exc(5'h08, 1'b0, 2'h1, 1'b0);
		#1;
		chk(cause[31], 1'b0);
	endtask : t_delay

	task automatic t_levels();
		p.set_status(1'b0, 1'b0, 1'b1);
		p.set_lines(1'b1, 1'b1, 3'h5);
		@(posedge clk);
		#1;
		chk(cause[30], 1'b1);
		chk(cause[26], 1'b1);
		chk(cause[12:10], 3'h5);
		p.set_lines(1'b0, 1'b0, 3'h0);
		@(posedge clk);
		#1;
		chk(cause, 32'h1000_0020);
		p.do_irq_return_instr(1'b1);
		#1;
		chk(cause[25], 1'b1);
		p.do_irq_return_instr(1'b0);
		#1;
		chk(cause[25], 1'b0);
	endtask : t_levels

	task automatic t_vector();
		p.set_status(1'b0, 1'b0, 1'b0);
		p.set_ctl(5'h01, 4'h9, 4'h3);
		wr(32'h0080_0000);
		p.take_exc(5'h00, 1'b0, 2'h0, 1'b0);
		#1;
		chk({voff, vtab, sset}, {12'h200, 1'b1, 4'h9});
		p.take_exc(5'h08, 1'b0, 2'h0, 1'b0);
		#1;
		chk({voff, vtab, sset}, {12'h180, 1'b0, 4'h3});
		p.set_ctl(5'h00, 4'h9, 4'h3);
		p.set_status(1'b0, 1'b1, 1'b0);
		p.take_exc(5'h00, 1'b0, 2'h0, 1'b0);
		#1;
		chk({voff, vtab, sset}, {12'h200, 1'b0, 4'h3});
		wr(32'h0000_0000);
		p.take_exc(5'h00, 1'b0, 2'h0, 1'b0);
		#1;
		chk({voff, vtab, sset}, {12'h180, 1'b0, 4'h3});
	endtask : t_vector

	task automatic t_rereset();
		wr(32'h0800_0000);
		p.do_irq_return_instr(1'b1);
		@(posedge clk);
		srst <= 1'b1;
		@(posedge clk);
		srst <= 1'b0;
		#1;
		chk(cause, 32'h0000_0000);
		chk(cnt, 32'h0000_0000);
		repeat (2) @(posedge clk);
		#1;
		chk(cnt, 32'h0000_0002);
		chk({sexp, sloc}, 4'h0);
	endtask : t_rereset

	// ***********************************************************
	// run control
	// ***********************************************************
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	initial begin
		repeat (2000) @(posedge clk);
		errors++;
		print_verdict();
	end

	initial begin
		errors = 0;
		check_count = 0;
		srst = 1'b1;
		we = 1'b0;
		wdata = 32'h0000_0000;
		t_reset();
		t_write();
		t_codes();
		t_delay();
		t_levels();
		t_vector();
		t_rereset();
		print_verdict();
	end
endmodule : testbench

// ==== verilog/ecs_cause.sv ====
// exception cause and status register with dispatch outputs
`timescale 1ns/100ps

// Function
// RL1 - only soft requests, halt, vector select writable
// RL2 - last exception code in bits six-two
// RL3 - interrupt zero, address faults four, five
// RL4 - fetch bus fault six, data seven
// RL5 - system call eight, break nine, illegal ten
// RL6 - unusable eleven, wrap twelve, halt thirteen
// RL7 - top bit flags exception in delay slot
// RL8 - delay flag updated only outside exception level
// RL9 - bit thirty shows timer interrupt pending
// RL10 - coprocessor unit field loaded every exception
// RL11 - count halt bit stops cycle counter
// RL12 - bit twenty-six shows counter interrupt pending
// RL13 - bit twenty-five shows chaining on return
// RL14 - bit twenty-four shows prologue exception
// RL15 - vector select picks special or general vector
// RL16 - select without boot flag means vector table
// RL17 - three-bit requested level, zero means none
// RL18 - set soft request bit means active request
// RL19 - soft requests exported in outer controller mode
// RL20 - unimplemented bits read as zero
// RL21 - shadow set from exception field unless vectored
// RL22 - halt, counter, chain, prologue reset zero
// RL23 - writes to read-only fields ignored
module ecs_cause
	import ecs_pkg::*;
(
	input wire logic I_CLK,
	input wire logic I_SRST,
	input wire ecs_exc_t I_EXC,
	input wire ecs_irq_return_instr_t I_IRQ_RETURN_INSTR,
	input wire ecs_status_t I_STATUS,
	input wire logic I_TIMER_IRQ,
	input wire logic I_PERF_IRQ,
	input wire logic [2:0] I_REQ_LEVEL,
	input wire logic [4:0] I_VECTOR_SPACING,
	input wire logic [3:0] I_MAPPED_SET,
	input wire logic [3:0] I_EXC_SHADOW_SET,
	input wire logic I_CAUSE_WE,
	input wire logic [31:0] I_CAUSE_WDATA,
	output logic [31:0] O_CAUSE,
	output logic [1:0] O_SOFT_IRQ_EXPORT,
	output logic [1:0] O_SOFT_IRQ_LOCAL,
	output logic O_COUNT_HALT,
	output logic [31:0] O_CYCLE_COUNT,
	output logic [11:0] O_VECTOR_OFFSET,
	output logic O_VECTOR_TABLE,
	output logic [3:0] O_SHADOW_SET
);

	// ***********************************************************
	// state
	// ***********************************************************
	logic branch_delay_flag_reg;
	logic countdown_irq_pending_reg;
	logic [1:0] cop_unit_reg;
	logic count_halt_reg;
	logic perf_irq_pending_reg;
	logic irq_chained_flag_reg;
	logic prologue_fault_flag_reg;
	logic vector_select_reg;
	logic [2:0] requested_level_reg;
	logic soft_irq_request_1_reg;
	logic soft_irq_request_0_reg;
	ecs_fault_code_t fault_code_reg;
	ecs_fault_code_t fault_code_next;
	logic [1:0] soft_export_reg;
	logic [1:0] soft_local_reg;
	logic [11:0] vector_offset_reg;
	logic vector_table_reg;
	logic [3:0] shadow_set_reg;
	logic is_interrupt;

	// ***********************************************************
	// code legalisation
	// ***********************************************************
	// reserved or unknown codes are never stored
	always_comb begin
		case (I_EXC.code)
			5'h00: fault_code_next = FC_INTERRUPT; // see RL3
			5'h04: fault_code_next = FC_ADDR_FAULT_LOAD; // see RL3
			5'h05: fault_code_next = FC_ADDR_FAULT_STORE; // see RL3
			5'h06: fault_code_next = FC_FETCH_BUS_FAULT; // see RL4
			5'h07: fault_code_next = FC_DATA_BUS_FAULT; // see RL4
			5'h08: fault_code_next = FC_SYSTEM_CALL; // see RL5
			5'h09: fault_code_next = FC_BREAK_CODE; // see RL5
			5'h0a: fault_code_next = FC_ILLEGAL_OPCODE_CODE; // see RL5
			5'h0b: fault_code_next = FC_COP_UNUSABLE; // see RL6
			5'h0c: fault_code_next = FC_ARITH_WRAP_CODE; // see RL6
			5'h0d: fault_code_next = FC_CONDITIONAL_HALT_CODE; // see RL6
			default: fault_code_next = FC_ILLEGAL_OPCODE_CODE; // see RL6
		endcase
	end

	assign is_interrupt = (fault_code_next == FC_INTERRUPT);

	// ***********************************************************
	// exception capture
	// ***********************************************************
	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			fault_code_reg <= FC_INTERRUPT;
			cop_unit_reg <= 2'h0;
		end else if (I_EXC.take) begin
			fault_code_reg <= fault_code_next; // see RL2
			cop_unit_reg <= I_EXC.cop_unit; // see RL10
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			branch_delay_flag_reg <= 1'b0;
		end else if (I_EXC.take && !I_STATUS.exception_level_flag) begin
			branch_delay_flag_reg <= I_EXC.in_delay; // see RL7, see RL8
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			prologue_fault_flag_reg <= 1'b0; // see RL22
		end else if (I_EXC.take) begin
			prologue_fault_flag_reg <= I_EXC.in_prologue; // see RL14
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			irq_chained_flag_reg <= 1'b0; // see RL22
		end else if (I_IRQ_RETURN_INSTR.done) begin
			irq_chained_flag_reg <= I_IRQ_RETURN_INSTR.chained; // see RL13
		end
	end

	// ***********************************************************
	// pending levels
	// ***********************************************************
	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			countdown_irq_pending_reg <= 1'b0;
			perf_irq_pending_reg <= 1'b0; // see RL22
			requested_level_reg <= LEVEL_NONE;
		end else begin
			countdown_irq_pending_reg <= I_TIMER_IRQ; // see RL9
			perf_irq_pending_reg <= I_PERF_IRQ; // see RL12
			requested_level_reg <= I_STATUS.outer_irq_ctrl_mode ?
				I_REQ_LEVEL : LEVEL_NONE; // see RL17
		end
	end

	// ***********************************************************
	// software writable fields
	// ***********************************************************
	// only these four bits take write data
	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			count_halt_reg <= 1'b0; // see RL22
			vector_select_reg <= 1'b0;
			soft_irq_request_1_reg <= 1'b0;
			soft_irq_request_0_reg <= 1'b0;
		end else if (I_CAUSE_WE) begin // see RL23
			count_halt_reg <= I_CAUSE_WDATA[DC_BIT]; // see RL1
			vector_select_reg <= I_CAUSE_WDATA[IV_BIT]; // see RL1
			soft_irq_request_1_reg <= I_CAUSE_WDATA[IP1_BIT]; // see RL18
			soft_irq_request_0_reg <= I_CAUSE_WDATA[IP0_BIT]; // see RL18
		end
	end

	// ***********************************************************
	// soft request routing
	// ***********************************************************
	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			soft_export_reg <= 2'h0;
			soft_local_reg <= 2'h0;
		end else if (I_STATUS.outer_irq_ctrl_mode) begin
			soft_export_reg <= {soft_irq_request_1_reg,
				soft_irq_request_0_reg}; // see RL19
			soft_local_reg <= 2'h0;
		end else begin
			soft_export_reg <= 2'h0;
			soft_local_reg <= {soft_irq_request_1_reg,
				soft_irq_request_0_reg}; // see RL18
		end
	end

	// ***********************************************************
	// dispatch
	// ***********************************************************
	always_ff @(posedge I_CLK) begin
		if (I_SRST) begin
			vector_offset_reg <= GEN_VEC_OFFSET;
			vector_table_reg <= 1'b0;
			shadow_set_reg <= 4'h0;
		end else if (I_EXC.take) begin
			vector_offset_reg <= (is_interrupt && vector_select_reg) ?
				INT_VEC_OFFSET : GEN_VEC_OFFSET; // see RL15
			vector_table_reg <= is_interrupt && vector_select_reg &&
				!I_STATUS.boot_vector_flag; // see RL16
			shadow_set_reg <= (is_interrupt && vector_select_reg &&
				(I_VECTOR_SPACING != SPACING_NONE)) ?
				I_MAPPED_SET : I_EXC_SHADOW_SET; // see RL21
		end
	end

	// ***********************************************************
	// cycle counter
	// ***********************************************************
	ecs_cycle_counter #(
		.WIDTH(32)
	) u_counter (
		.i_clk(I_CLK),
		.i_srst(I_SRST),
		.i_enable(!count_halt_reg), // see RL11
		.o_count(O_CYCLE_COUNT)
	);

	// ***********************************************************
	// read view
	// ***********************************************************
	// unlisted positions stay zero
	always_comb begin
		O_CAUSE = CAUSE_RESET; // see RL20
		O_CAUSE[BD_BIT] = branch_delay_flag_reg;
		O_CAUSE[TI_BIT] = countdown_irq_pending_reg;
		O_CAUSE[CE_HI:CE_LO] = cop_unit_reg;
		O_CAUSE[DC_BIT] = count_halt_reg;
		O_CAUSE[PCI_BIT] = perf_irq_pending_reg;
		O_CAUSE[IC_BIT] = irq_chained_flag_reg;
		O_CAUSE[AP_BIT] = prologue_fault_flag_reg;
		O_CAUSE[IV_BIT] = vector_select_reg;
		O_CAUSE[REQUESTED_LEVEL_HI:REQUESTED_LEVEL_LO] = requested_level_reg;
		O_CAUSE[IP1_BIT] = soft_irq_request_1_reg;
		O_CAUSE[IP0_BIT] = soft_irq_request_0_reg;
		O_CAUSE[CODE_HI:CODE_LO] = fault_code_reg; // see RL2
	end

	assign O_SOFT_IRQ_EXPORT = soft_export_reg;
	assign O_SOFT_IRQ_LOCAL = soft_local_reg;
	assign O_COUNT_HALT = count_halt_reg;
	assign O_VECTOR_OFFSET = vector_offset_reg;
	assign O_VECTOR_TABLE = vector_table_reg;
	assign O_SHADOW_SET = shadow_set_reg;

	// ***********************************************************
	// assertions
	// ***********************************************************
	// low for one cycle after any reset, so the counter checks skip
	// the edge whose sampled values still predate the reset
	logic run_reg;

	always_ff @(posedge I_CLK) begin
		run_reg <= !I_SRST;
	end

	property p_write_keeps_ro;
		@(posedge I_CLK) disable iff (I_SRST)
		(I_CAUSE_WE && !I_EXC.take && !I_IRQ_RETURN_INSTR.done) |=>
		(O_CAUSE[CE_HI:CE_LO] == $past(O_CAUSE[CE_HI:CE_LO])) &&
		(O_CAUSE[CODE_HI:CODE_LO] == $past(O_CAUSE[CODE_HI:CODE_LO])) &&
		(O_CAUSE[IC_BIT:AP_BIT] == $past(O_CAUSE[IC_BIT:AP_BIT]));
	endproperty
	a_write_keeps_ro: assert property (p_write_keeps_ro) // see RL1, see RL23
		else $error("write altered a read-only cause field");

	property p_code_load;
		@(posedge I_CLK) disable iff (I_SRST)
		I_EXC.take |=> O_CAUSE[CODE_HI:CODE_LO] == $past(fault_code_next);
	endproperty
	a_code_load: assert property (p_code_load) // see RL2
		else $error("exception code not loaded");

	property p_no_reserved_code;
		@(posedge I_CLK) disable iff (I_SRST)
		I_EXC.take |=> (O_CAUSE[CODE_HI:CODE_LO] < 5'h0e) &&
		(O_CAUSE[CODE_HI:CODE_LO] == 5'h00 ||
		O_CAUSE[CODE_HI:CODE_LO] > 5'h03);
	endproperty
	a_no_reserved_code: assert property (p_no_reserved_code) // see RL6
		else $error("reserved exception code stored");

	property p_delay_hold;
		@(posedge I_CLK) disable iff (I_SRST)
		(I_EXC.take && I_STATUS.exception_level_flag) |=>
		$stable(O_CAUSE[BD_BIT]);
	endproperty
	a_delay_hold: assert property (p_delay_hold) // see RL8
		else $error("delay flag changed at exception level");

	property p_delay_load;
		@(posedge I_CLK) disable iff (I_SRST)
		(I_EXC.take && !I_STATUS.exception_level_flag) |=>
		O_CAUSE[BD_BIT] == $past(I_EXC.in_delay);
	endproperty
	a_delay_load: assert property (p_delay_load) // see RL7
		else $error("delay flag not loaded");

	property p_halt_stops;
		@(posedge I_CLK) disable iff (I_SRST || !run_reg)
		O_COUNT_HALT |=> $stable(O_CYCLE_COUNT);
	endproperty
	a_halt_stops: assert property (p_halt_stops) // see RL11
		else $error("counter moved while halted");

	property p_count_runs;
		@(posedge I_CLK) disable iff (I_SRST || !run_reg)
		!O_COUNT_HALT |=> O_CYCLE_COUNT == $past(O_CYCLE_COUNT) + 32'h0000_0001;
	endproperty
	a_count_runs: assert property (p_count_runs) // see RL11
		else $error("counter did not advance");

	property p_vector_pick;
		@(posedge I_CLK) disable iff (I_SRST)
		(I_EXC.take && is_interrupt) |=>
		O_VECTOR_OFFSET == ($past(vector_select_reg) ?
		INT_VEC_OFFSET : GEN_VEC_OFFSET);
	endproperty
	a_vector_pick: assert property (p_vector_pick) // see RL15
		else $error("wrong interrupt vector offset");

	property p_zero_bits;
		@(posedge I_CLK) disable iff (I_SRST)
		(O_CAUSE[22:13] == 10'h000) && !O_CAUSE[7] && (O_CAUSE[1:0] == 2'h0);
	endproperty
	a_zero_bits: assert property (p_zero_bits) // see RL20
		else $error("unimplemented cause bit set");

	property p_soft_export;
		@(posedge I_CLK) disable iff (I_SRST)
		I_STATUS.outer_irq_ctrl_mode |=>
		O_SOFT_IRQ_EXPORT == $past(O_CAUSE[IP1_BIT:IP0_BIT]);
	endproperty
	a_soft_export: assert property (p_soft_export) // see RL19
		else $error("soft requests not exported");

	property p_reset_zero;
		@(posedge I_CLK)
		I_SRST |=> !O_COUNT_HALT && !O_CAUSE[PCI_BIT] &&
		!O_CAUSE[IC_BIT] && !O_CAUSE[AP_BIT];
	endproperty
	a_reset_zero: assert property (p_reset_zero) // see RL22
		else $error("reset value wrong");

	property p_level_none;
		@(posedge I_CLK) disable iff (I_SRST)
		!I_STATUS.outer_irq_ctrl_mode |=> O_CAUSE[REQUESTED_LEVEL_HI:REQUESTED_LEVEL_LO] == 3'h0;
	endproperty
	a_level_none: assert property (p_level_none) // see RL17
		else $error("level shown outside controller mode");

	c_vectored_irq: cover property (@(posedge I_CLK) disable iff (I_SRST)
		I_EXC.take && is_interrupt && vector_select_reg);
	c_delay_slot: cover property (@(posedge I_CLK) disable iff (I_SRST)
		I_EXC.take && I_EXC.in_delay && !I_STATUS.exception_level_flag);
	c_chained: cover property (@(posedge I_CLK) disable iff (I_SRST)
		I_IRQ_RETURN_INSTR.done && I_IRQ_RETURN_INSTR.chained);
	c_halt: cover property (@(posedge I_CLK) disable iff (I_SRST)
		I_CAUSE_WE && I_CAUSE_WDATA[DC_BIT]);

endmodule : ecs_cause

// ==== verilog/ecs_cycle_counter.sv ====
// free running cycle counter with a stop enable
`timescale 1ns/100ps
module ecs_cycle_counter
	import ecs_pkg::*;
#(
	parameter int WIDTH = 32
) (
	input wire logic i_clk,
	input wire logic i_srst,
	input wire logic i_enable,
	output logic [WIDTH-1:0] o_count
);

	// ***********************************************************
	// counter
	// ***********************************************************
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_count <= COUNT_RESET[WIDTH-1:0];
		end else if (i_enable) begin
			o_count <= o_count + WIDTH'(1);
		end
	end

endmodule : ecs_cycle_counter

// ==== verilog/ecs_pkg.sv ====
// shared constants, codes and carriers of the exception cause block
package ecs_pkg;

	// ***********************************************************
	// cause word field positions
	// ***********************************************************
	localparam int CAUSE_W = 32;
	localparam int BD_BIT = 31;
	localparam int TI_BIT = 30;
	localparam int CE_HI = 29;
	localparam int CE_LO = 28;
	localparam int DC_BIT = 27;
	localparam int PCI_BIT = 26;
	localparam int IC_BIT = 25;
	localparam int AP_BIT = 24;
	localparam int IV_BIT = 23;
	localparam int REQUESTED_LEVEL_HI = 12;
	localparam int REQUESTED_LEVEL_LO = 10;
	localparam int IP1_BIT = 9;
	localparam int IP0_BIT = 8;
	localparam int CODE_HI = 6;
	localparam int CODE_LO = 2;

	// ***********************************************************
	// vector offsets and reset values
	// ***********************************************************
	localparam logic [11:0] GEN_VEC_OFFSET = 12'h180;
	localparam logic [11:0] INT_VEC_OFFSET = 12'h200;
	localparam logic [31:0] CAUSE_RESET = 32'h0000_0000;
	localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
	localparam logic [2:0] LEVEL_NONE = 3'h0;
	localparam logic [4:0] SPACING_NONE = 5'h00;

	// ***********************************************************
	// exception codes
	// ***********************************************************
	typedef enum logic [4:0] {
		FC_INTERRUPT = 5'b00000,
		FC_ADDR_FAULT_LOAD = 5'b00100,
		FC_ADDR_FAULT_STORE = 5'b00101,
		FC_FETCH_BUS_FAULT = 5'b00110,
		FC_DATA_BUS_FAULT = 5'b00111,
		FC_SYSTEM_CALL = 5'b01000,
		FC_BREAK_CODE = 5'b01001,
		FC_ILLEGAL_OPCODE_CODE = 5'b01010,
		FC_COP_UNUSABLE = 5'b01011,
		FC_ARITH_WRAP_CODE = 5'b01100,
		FC_CONDITIONAL_HALT_CODE = 5'b01101
	} ecs_fault_code_t;

	// ***********************************************************
	// carriers
	// ***********************************************************
	typedef struct packed {
		logic take;
		logic [4:0] code;
		logic in_delay;
		logic [1:0] cop_unit;
		logic in_prologue;
	} ecs_exc_t;

	typedef struct packed {
		logic done;
		logic chained;
	} ecs_irq_return_instr_t;

	typedef struct packed {
		logic exception_level_flag;
		logic boot_vector_flag;
		logic outer_irq_ctrl_mode;
	} ecs_status_t;

endpackage : ecs_pkg
